/* File: rtl/mgw_params.svh */
// constants for the measurement gate window generator
// assumes a 40 MHz system clock and a 1 us timebase derived from it
`ifndef MGW_PARAMS_SVH
`define MGW_PARAMS_SVH
`define MGW_CLK_PERIOD_PS   25000
`define MGW_TICK_PERIOD_PS  1000000
`define MGW_TICK_CYCLES     (`MGW_TICK_PERIOD_PS / `MGW_CLK_PERIOD_PS)
`define MGW_TICK_W          6
`define MGW_DIGIT_W         4
`define MGW_DECADES         3
`define MGW_MANT_W          12
`define MGW_EXP_MAX         4'h7
`define MGW_DIGIT_MAX       4'h9
`define MGW_DIGIT_ZERO      4'h0
`define MGW_DIGIT_ONE       4'h1
`define MGW_MANT_RESET      12'h001
`define MGW_EXP_RESET       4'h0
`define MGW_EXP_LAST        32'h1
`define MGW_POW10_0         32'h1
`define MGW_POW10_1         32'hA
`define MGW_POW10_2         32'h64
`define MGW_POW10_3         32'h3E8
`define MGW_POW10_4         32'h2710
`define MGW_POW10_5         32'h186A0
`define MGW_POW10_6         32'hF4240
`define MGW_POW10_7         32'h989680
`endif

/* File: rtl/mgw_pkg.sv */
// types for the measurement gate window generator
// assumes mgw_params.svh is included by each user
package mgw_pkg;
  typedef enum logic [2:0] {
    MGW_IDLE = 3'b001,
    MGW_RUN  = 3'b010,
    MGW_DONE = 3'b100
  } mgw_state_t;
endpackage : mgw_pkg

/* File: rtl/mgw_decade.sv */
// one bcd decade down-counter with preset and borrow-out
// assumes count enable and load are single-cycle pulses on clk_sys
`timescale 1ns/1ps
`include "mgw_params.svh"
module mgw_decade (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // control
  input  wire logic       load,
  input  wire logic [3:0] preset,
  input  wire logic       countEn,
  // status
  output logic       [3:0] digit,
  output logic             borrow
);
  logic [3:0] next_digit;

  always_comb begin
    next_digit = digit;
    if (load) begin
      next_digit = preset;
    end else if (countEn) begin
      if (digit == `MGW_DIGIT_ZERO) begin
        next_digit = `MGW_DIGIT_MAX;
      end else begin
        next_digit = digit - 4'h1;
      end
    end
  end

  // borrow is combinational so the decade chain ripples in one cycle
  assign borrow = countEn && (digit == `MGW_DIGIT_ZERO);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      digit <= `MGW_DIGIT_ZERO;
    end else begin
      digit <= next_digit;
    end
  end
endmodule : mgw_decade

/* File: rtl/mgw_gate_gen.sv */
// measurement gate window generator: mantissa x 10^exponent microseconds
// assumes start is a one-cycle pulse and settings are stable while a window runs
`timescale 1ns/1ps
`include "mgw_params.svh"
// Behaviour
// - the mantissa is three bcd digits on twelve preset lines loaded into three cascaded decade down-counters.
// - each mantissa decade above the first steps on the borrow of the one below, so the three digits give the matching three-digit count.
// - mantissa holding registers keep the programmed value so the counters can be reloaded again and again.
// - a tick with the mantissa at 001 (mantEnd) makes a load pulse that presets the mantissa counters again, except on the last period (decadeOut).
// - the exponent counter counts mantissa periods down by ten to the exponent and its decade-out ends the window.
// - the exponent runs from 0 to 7, giving 1 us to 10^7 us windows for a mantissa of one.
// - the exponent is captured in a clocked register whose outputs preset the exponent counter.
// - the exponent counter is preset to ten to the held exponent and has a count input driven by the mantissa stage.
// - the window is timed in microsecond units.
// - the finished window leaves on the rear output and the mainframe gates on it and measures its length.
// - the gate signal passes through output buffer stages and is the measurement gate output.
module mgw_gate_gen (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // settings
  input  wire logic [11:0] mantissaIn,
  input  wire logic        mantissaWr,
  input  wire logic [3:0]  exponentIn,
  input  wire logic        exponentWr,
  // control
  input  wire logic        start,
  // outputs
  output logic             gate_window_out,
  output logic             windowDone
);
  // holding registers
  logic [11:0] mantHold;
  logic [11:0] next_mantHold;
  logic [3:0]  expHold;
  logic [3:0]  next_expHold;

  // microsecond timebase
  logic [5:0]  tickCnt;
  logic [5:0]  next_tickCnt;
  logic        tick;

  // sequencing
  mgw_pkg::mgw_state_t state;
  mgw_pkg::mgw_state_t next_state;
  logic        mantLoad;
  logic [31:0] expCnt;
  logic [31:0] next_expCnt;
  logic        gateBuf;
  logic        next_gateBuf;
  logic        next_gateOut;
  logic        next_done;

  // decade chain
  logic [3:0]  digits [`MGW_DECADES];
  logic [`MGW_DECADES-1:0] borrows;
  logic [`MGW_DECADES:0]   carryEn;
  logic        mantZero;
  logic        mantEnd;
  logic        decadeOut;

  function automatic logic [31:0] pow10(input logic [3:0] e);
    logic [31:0] r;
    // a table instead of a multiply loop keeps the preset path shallow
    unique case (e)
      4'h0: r = `MGW_POW10_0;
      4'h1: r = `MGW_POW10_1;
      4'h2: r = `MGW_POW10_2;
      4'h3: r = `MGW_POW10_3;
      4'h4: r = `MGW_POW10_4;
      4'h5: r = `MGW_POW10_5;
      4'h6: r = `MGW_POW10_6;
      default: r = `MGW_POW10_7; // held exponents are clamped, so only 7 lands here
    endcase
    return r;
  endfunction : pow10

  // settings registers
  always_comb begin
    next_mantHold = mantHold;
    next_expHold  = expHold;
    if (mantissaWr) begin
      next_mantHold = mantissaIn;
    end
    if (exponentWr) begin
      // out-of-range exponents clamp to the largest decade
      next_expHold = (exponentIn > `MGW_EXP_MAX) ? `MGW_EXP_MAX : exponentIn;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mantHold <= `MGW_MANT_RESET;
      expHold  <= `MGW_EXP_RESET;
    end else begin
      mantHold <= next_mantHold;
      expHold  <= next_expHold;
    end
  end

  // 1 us tick from 40 MHz
  always_comb begin
    next_tickCnt = tickCnt;
    tick = 1'b0;
    if (state == mgw_pkg::MGW_RUN) begin
      if (tickCnt == 6'(`MGW_TICK_CYCLES - 1)) begin
        next_tickCnt = 6'h00;
        tick = 1'b1;
      end else begin
        next_tickCnt = tickCnt + 6'h01;
      end
    end else begin
      next_tickCnt = 6'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tickCnt <= 6'h00;
    end else begin
      tickCnt <= next_tickCnt;
    end
  end

  // the first decade steps on tick; each decade above it only steps on the borrow of the one below
  assign carryEn[0] = tick;
  generate
    for (genvar g = 0; g < `MGW_DECADES; g++) begin : g_dec
      mgw_decade u_dec (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .load    (mantLoad),
        .preset  (mantHold[g*`MGW_DIGIT_W +: `MGW_DIGIT_W]),
        .countEn (carryEn[g]),
        .digit   (digits[g]),
        .borrow  (borrows[g])
      );
      assign carryEn[g+1] = borrows[g];
    end
  endgenerate

  // a period is complete when the whole mantissa reads 001 on a tick;
  // this stands in for the top-decade borrow and avoids the extra count it implies
  assign mantZero = (digits[0] == `MGW_DIGIT_ONE) && (digits[1] == `MGW_DIGIT_ZERO) &&
                    (digits[2] == `MGW_DIGIT_ZERO);
  assign mantEnd  = tick && mantZero;
  assign decadeOut = mantEnd && (expCnt == `MGW_EXP_LAST);

  // sequencing and exponent counter
  always_comb begin
    next_state   = state;
    next_expCnt  = expCnt;
    mantLoad     = 1'b0;
    next_gateBuf = gateBuf;
    next_done    = 1'b0;
    unique case (state)
      mgw_pkg::MGW_IDLE: begin
        next_gateBuf = 1'b0;
        if (start && (mantHold != 12'h000)) begin
          mantLoad     = 1'b1;
          next_expCnt  = pow10(expHold); // preset to ten to the held exponent
          next_gateBuf = 1'b1;
          next_state   = mgw_pkg::MGW_RUN;
        end
      end
      mgw_pkg::MGW_RUN: begin
        if (decadeOut) begin
          next_gateBuf = 1'b0;
          next_state   = mgw_pkg::MGW_DONE;
        end else if (mantEnd) begin
          mantLoad    = 1'b1; // gate untouched across reloads
          next_expCnt = expCnt - 32'h1; // counted by the mantissa stage
        end
      end
      mgw_pkg::MGW_DONE: begin
        next_done  = 1'b1;
        next_state = mgw_pkg::MGW_IDLE;
      end
      default: begin
        next_state   = mgw_pkg::MGW_IDLE;
        next_gateBuf = 1'b0;
      end
    endcase
    next_gateOut = gateBuf; // second buffer stage
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state           <= mgw_pkg::MGW_IDLE;
      expCnt          <= 32'h0;
      gateBuf         <= 1'b0;
      gate_window_out <= 1'b0;
      windowDone      <= 1'b0;
    end else begin
      state           <= next_state;
      expCnt          <= next_expCnt;
      gateBuf         <= next_gateBuf;
      gate_window_out <= next_gateOut;
      windowDone      <= next_done;
    end
  end
endmodule : mgw_gate_gen

/* File: sim/mgw_gate_gen_properties.sv */
// port checker for the gate window generator
// assumes it is bound onto mgw_gate_gen and sees one clock
`timescale 1ns/1ps
module mgw_chk (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_b,
  // settings and control
  input wire logic [11:0] mantissaIn,
  input wire logic        mantissaWr,
  input wire logic [3:0]  exponentIn,
  input wire logic        exponentWr,
  input wire logic        start,
  // outputs
  input wire logic        gate_window_out,
  input wire logic        windowDone
);
  logic [11:0] hm;
  logic [3:0]  he;
  int          hi;
  int          want;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // shadow of the holding registers so the length can be judged
  always_ff @(posedge clk_sys) begin
    hm <= !rst_b ? 12'h001 : mantissaWr ? mantissaIn : hm;
    he <= !rst_b ? 4'h0 : exponentWr ? (exponentIn > 4'h7 ? 4'h7 : exponentIn) : he;
    hi <= gate_window_out ? hi + 1 : 0;
  end
  always_comb want = 40 * (hm[11:8] * 100 + hm[7:4] * 10 + hm[3:0]) * 10 ** he;
  property p_done; windowDone |-> $fell(gate_window_out); endproperty
  a_done: assert property (p_done) else $error("done without gate end");
  property p_one; windowDone |=> !windowDone; endproperty
  a_one: assert property (p_one) else $error("done too long");
  property p_fall; $fell(gate_window_out) |-> windowDone; endproperty
  a_fall: assert property (p_fall) else $error("gate dropped early");
  property p_go; start && !gate_window_out && !windowDone && hm != 12'h000 && !$past(start)
    |=> !gate_window_out ##1 gate_window_out; endproperty
  a_go: assert property (p_go) else $error("gate not opened");
  property p_zero; start && !gate_window_out && hm == 12'h000 |=> !gate_window_out [*2]; endproperty
  a_zero: assert property (p_zero) else $error("zero mantissa ran");
  property p_len; $fell(gate_window_out) |-> hi == want; endproperty
  a_len: assert property (p_len) else $error("window length");
  property p_rose; $rose(gate_window_out) |-> $past(start, 2); endproperty
  a_rose: assert property (p_rose) else $error("gate opened alone");
  property p_excl; gate_window_out |-> !windowDone; endproperty
  a_excl: assert property (p_excl) else $error("done while open");
endmodule : mgw_chk
bind mgw_gate_gen mgw_chk i_chk (.clk_sys(clk_sys), .rst_b(rst_b), .mantissaIn(mantissaIn),
  .mantissaWr(mantissaWr), .exponentIn(exponentIn), .exponentWr(exponentWr), .start(start),
  .gate_window_out(gate_window_out), .windowDone(windowDone));

/* File: sim/mgw_host_model.sv */
// host mainframe model: times the external gate in clock cycles
// assumes the gate is low after reset
`timescale 1ns/1ps
module mgw_host_model (
  // clock and gate
  input wire logic clk_sys,
  input wire logic gate_window_out,
  // measured interval
  output int       lengthCyc,
  output logic     measDone
);
  int cnt = 0;
  initial measDone = 1'b0;
  always @(posedge clk_sys) begin
    measDone <= 1'b0;
    if (gate_window_out === 1'b1) cnt <= cnt + 1;
    else if (cnt != 0) begin
      lengthCyc <= cnt;
      measDone <= 1'b1;
      cnt <= 0;
    end
  end
endmodule : mgw_host_model

/* File: sim/test_mgw_gate_gen.sv */
// self-checking bench for the gate window generator
// assumes the design, the checker bind and the host model are compiled first
`timescale 1ns/1ps
module test_mgw_gate_gen;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic [11:0] mantissaIn = 12'h000;
  logic        mantissaWr = 1'b0;
  logic [3:0]  exponentIn = 4'h0;
  logic        exponentWr = 1'b0;
  logic        start = 1'b0;
  logic        gate_window_out;
  logic        windowDone;
  logic        measDone;
  int          lengthCyc;
  int          fails = 0;
  int          check_count = 0;
  int          expQ[$];
  int          k;
  always #12.5 clk_sys = ~clk_sys;
  mgw_gate_gen i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .mantissaIn(mantissaIn), .mantissaWr(mantissaWr),
    .exponentIn(exponentIn), .exponentWr(exponentWr), .start(start), .gate_window_out(gate_window_out),
    .windowDone(windowDone));
  mgw_host_model i_host (.clk_sys(clk_sys), .gate_window_out(gate_window_out), .lengthCyc(lengthCyc),
    .measDone(measDone));
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (exp !== got) begin
      fails++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check
  // poke holds start into the first run cycle, which must be ignored
  task automatic runWindow(input logic [11:0] m, input logic [3:0] e, input logic poke);
    int n;
    logic sawDone;
    sawDone = 1'b0;
    mantissaIn = m;
    exponentIn = e;
    mantissaWr = 1'b1;
    exponentWr = 1'b1;
    step(1);
    mantissaWr = 1'b0;
    exponentWr = 1'b0;
    start = 1'b1;
    if (m != 12'h000) expQ.push_back(40 * (m[11:8] * 100 + m[7:4] * 10 + m[3:0]) * 10 ** e);
    step(1);
    start = poke;
    step(1);
    start = 1'b0;
    check("gate", m != 12'h000, gate_window_out);
    for (n = 0; n < 50000 && measDone !== 1'b1 && (m != 12'h000 || n < 60); n++) begin
      step(1);
      if (windowDone === 1'b1) sawDone = 1'b1;
    end
    check("measured", m != 12'h000, measDone);
    check("done", m != 12'h000, sawDone);
    if (m != 12'h000) check("length", expQ.pop_front(), lengthCyc);
    $display("test %h e%0d done", m, e);
  endtask : runWindow
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  initial begin
    #2400000;
    fails++;
    summarize();
  end
  initial begin
    void'($urandom(32'hD22C));
    step(20);
    rst_b = 1'b1;
    runWindow(12'h000, 4'h0, 1'b0);
    for (k = 0; k < 3; k++) runWindow(12'h001, 4'(k), 1'b0);
    for (k = 0; k < 12; k++) runWindow(12'(1 << k), 4'h0, 1'b0);
    runWindow(12'h111, 4'h0, 1'b0);
    runWindow(12'h012, 4'h1, 1'b1);
    repeat (2) runWindow({4'h0, 4'($urandom % 10), 4'($urandom % 10)}, 4'h0, 1'b0);
    summarize();
  end
endmodule : test_mgw_gate_gen
